// ==== shared/vic_defines.vh ====
// Constants for the vectored interrupt controller: register offsets,
// field positions, reset values, table geometry and fixed latencies.
// Assumes a 100 MHz core clock and a 32-bit classic Wishbone slave port.
`ifndef VIC_DEFINES_VH
`define VIC_DEFINES_VH

// ----------------------------------------------------------------------
// Table geometry
// ----------------------------------------------------------------------
`define VIC_NSLOT 80
`define VIC_NTRAP 5
`define VIC_TRAP_VECS 7'h08
`define VIC_NVEC 8'h7E
`define VIC_IVT_BASE 24'h000004
`define VIC_ALTERNATE_VECTOR_TABLE_BASE 24'h000100
`define VIC_RESET_PC 24'h000000

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define VIC_CTRL_OFS 8'h00
`define VIC_EN_OFS 8'h04
`define VIC_EN_LAST 8'h14
`define VIC_STATE_OFS 8'h30
`define VIC_EVT_STAT_OFS 8'h34
`define VIC_EVT_CLR_OFS 8'h38
`define VIC_EVT_EN_OFS 8'h3C
`define VIC_PRI_OFS 8'h40
`define VIC_PRI_LAST 8'h8C

// ----------------------------------------------------------------------
// Fields, masks and reset values
// ----------------------------------------------------------------------
`define VIC_ALT_BIT 15
`define VIC_EN_MASK 80'h001F_FFFF_FFFF_7FFB_FFFF
`define VIC_PRI_RESET 4'h4
`define VIC_TRAP_LVL 4'h8
`define VIC_EVT_TAKEN 0
`define VIC_EVT_TRAP 1
`define VIC_EVT_RET 2

// ----------------------------------------------------------------------
// Fixed latencies in core clock cycles
// ----------------------------------------------------------------------
`define VIC_RET_CYCLES 3'h3

`endif

// ==== hw/vic_top.v ====
// Vectored interrupt controller: arbitration, vector fetch, registers.
// Assumes program memory drives data while its fetch strobe is high,
// and that all source and core inputs are synchronous to core_clk.
`timescale 1ns/1ps
`include "vic_defines.vh"

// Behaviour
// - Pending enabled requests with a level above the core level, and all traps, merge into one request line to the core.
// - Seven software priority levels, plus up to eight trap vectors.
// - Primary vector table starts at program word address 000004h.
// - Table holds 126 entries: eight traps then up to 118 interrupts.
// - Each source owns its own vector entry.
// - Each entry gives a 24-bit handler address passed to the core.
// - Ties go to the lower vector; vector 0 is naturally highest.
// - Same-level requests are ordered by natural vector order.
// - Up to 67 interrupt sources and five non-maskable traps.
// - Control bit 15 set makes all vector fetches use the alternate table.
// - Alternate table follows the primary with identical layout.
// - Entry and return take a fixed cycle count for every source.
// - Reset clears registers except priorities (level 4), PC goes to zero, controller uninvolved.
// - Enable bit 1 passes a source to arbitration, 0 blocks it.
// - Second enable word: bit3 change notify, bit1 and 0 I2C, bit2 zero.
// - Core level is the top bit joined with the three-bit status field.
module vic_top (
	// Clock and reset
	input wire core_clk,
	input wire rst_n,
	// Wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	output wire wb_ack_o,
	// Sources
	input wire [79:0] src_irq,
	input wire [4:0] trap_req,
	// Core side
	input wire core_priority_top_bit,
	input wire [2:0] status_priority_field,
	output wire core_irq_req,
	input wire core_irq_ack,
	input wire core_ret,
	output wire [6:0] taken_vector,
	output wire [3:0] taken_level,
	output wire [23:0] isr_addr,
	output wire isr_valid,
	output wire ret_done,
	// Program memory vector fetch
	output wire [23:0] pm_addr,
	output wire pm_rd,
	input wire [23:0] pm_data,
	// Interrupt to the host
	output wire host_irq
);

// ----------------------------------------------------------------------
// States
// ----------------------------------------------------------------------
localparam ST_IDLE = 3'd0;
localparam ST_FETCH = 3'd1;
localparam ST_LOAD = 3'd2;
localparam ST_BUSY = 3'd3;
localparam ST_RET = 3'd4;

function is_pri;
	input [7:0] a;
	begin
		is_pri = (a >= `VIC_PRI_OFS) && (a <= `VIC_PRI_LAST) &&
			(a[1:0] == 2'b00);
	end
endfunction

function is_en;
	input [7:0] a;
	begin
		is_en = (a >= `VIC_EN_OFS) && (a <= `VIC_EN_LAST) &&
			(a[1:0] == 2'b00);
	end
endfunction

// ----------------------------------------------------------------------
// Storage
// ----------------------------------------------------------------------
reg ack_ff;
reg [31:0] rdat_ff;
reg [31:0] nxt_rdat;
reg alt_sel_ff;
reg [79:0] en_ff;
reg [319:0] pri_ff;
reg [2:0] evt_stat_ff;
reg [2:0] evt_en_ff;
reg [2:0] state_ff;
reg [2:0] nxt_state;
reg [6:0] vec_ff;
reg [3:0] lvl_ff;
reg is_trap_ff;
reg [23:0] pm_addr_ff;
reg pm_rd_ff;
reg [23:0] isr_addr_ff;
reg isr_valid_ff;
reg ret_done_ff;
reg [2:0] ret_cnt_ff;

wire acc = wb_cyc_i & wb_stb_i;
// Writes land on the ack edge, so a held request writes again on each ack, every other cycle
wire wr_go = acc & wb_we_i & ack_ff;
wire [2:0] en_idx = wb_adr_i[4:2] - 3'h1;
wire [4:0] pri_idx = wb_adr_i[6:2] - 5'h10;

// ----------------------------------------------------------------------
// Address decode
// ----------------------------------------------------------------------
wire hit_ctrl = (wb_adr_i == `VIC_CTRL_OFS);
wire hit_en = is_en(wb_adr_i);
wire hit_state = (wb_adr_i == `VIC_STATE_OFS);
wire hit_stat = (wb_adr_i == `VIC_EVT_STAT_OFS);
wire hit_clr = (wb_adr_i == `VIC_EVT_CLR_OFS);
wire hit_evt_en = (wb_adr_i == `VIC_EVT_EN_OFS);
wire hit_pri = is_pri(wb_adr_i);
wire [3:0] core_lvl = {core_priority_top_bit, status_priority_field};

// ----------------------------------------------------------------------
// Arbitration
// ----------------------------------------------------------------------
reg [3:0] best_lvl;
reg [6:0] best_idx;
reg best_ok;
reg [3:0] slot_lvl;
reg trap_ok;
reg [6:0] trap_vec;
integer i;
integer k;

// Unbuilt slots masked again here so a stray bit can never request
wire [79:0] en_mask = `VIC_EN_MASK;
wire [79:0] en_eff = en_ff & en_mask;

always @* begin
	best_lvl = 4'h0;
	best_idx = 7'h00;
	best_ok = 1'b0;
	slot_lvl = 4'h0;
	// Scan downward with >= so the lowest slot wins ties
	for (i = 79; i >= 0; i = i - 1) begin
		slot_lvl = {1'b0, pri_ff[i*4 +: 3]};
		if (src_irq[i] && en_eff[i] && slot_lvl != 4'h0 &&
			slot_lvl >= best_lvl) begin
			best_lvl = slot_lvl;
			best_idx = i[6:0];
			best_ok = 1'b1;
		end
	end
end

always @* begin
	trap_ok = 1'b0;
	trap_vec = 7'h00;
	// Traps ignore enables and priority registers
	for (k = 4; k >= 0; k = k - 1) begin
		if (trap_req[k]) begin
			trap_ok = 1'b1;
			trap_vec = k[6:0];
		end
	end
end

wire [6:0] win_vec = trap_ok ? trap_vec :
	best_idx + `VIC_TRAP_VECS;
wire [3:0] win_lvl = trap_ok ? `VIC_TRAP_LVL : best_lvl;
// Traps skip the core level test: they are non-maskable
wire win_ok = trap_ok | (best_ok & (best_lvl > core_lvl));

// Combinational so a new winner reaches the core at once
assign core_irq_req = (state_ff == ST_IDLE) & win_ok;

// ----------------------------------------------------------------------
// Entry and return sequencer
// ----------------------------------------------------------------------
// Alternate base sits right after the 126-entry primary table
wire [23:0] tbl_base = alt_sel_ff ? `VIC_ALTERNATE_VECTOR_TABLE_BASE : `VIC_IVT_BASE;
// Each 24-bit entry spans two program words
wire [23:0] vec_addr = tbl_base + {16'h0000, vec_ff, 1'b0};

always @* begin
	nxt_state = state_ff;
	case (state_ff)
	ST_IDLE: begin
		if (core_irq_req && core_irq_ack)
			nxt_state = ST_FETCH;
	end
	ST_FETCH: nxt_state = ST_LOAD;
	ST_LOAD: nxt_state = ST_BUSY;
	ST_BUSY: begin
		if (core_ret)
			nxt_state = ST_RET;
	end
	ST_RET: begin
		if (ret_cnt_ff == 3'h1)
			nxt_state = ST_IDLE;
	end
	default: nxt_state = ST_IDLE;
	endcase
end

// Controller holds still in reset; the core restarts from zero alone
always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n) begin
		state_ff <= ST_IDLE;
		vec_ff <= 7'h00;
		lvl_ff <= 4'h0;
		is_trap_ff <= 1'b0;
		pm_addr_ff <= `VIC_RESET_PC;
		pm_rd_ff <= 1'b0;
		isr_addr_ff <= `VIC_RESET_PC;
		isr_valid_ff <= 1'b0;
		ret_done_ff <= 1'b0;
		ret_cnt_ff <= 3'h0;
	end else begin
		state_ff <= nxt_state;
		pm_rd_ff <= 1'b0;
		isr_valid_ff <= 1'b0;
		ret_done_ff <= 1'b0;
		if (state_ff == ST_IDLE && core_irq_req && core_irq_ack) begin
			vec_ff <= win_vec;
			lvl_ff <= win_lvl;
			is_trap_ff <= trap_ok;
		end
		// Latched vector is stable since the take edge
		if (state_ff == ST_FETCH) begin
			pm_addr_ff <= vec_addr;
			pm_rd_ff <= 1'b1;
		end
		if (state_ff == ST_LOAD) begin
			isr_addr_ff <= pm_data;
			isr_valid_ff <= 1'b1;
		end
		// Counter ends at one so every return takes the same cycles
		if (state_ff == ST_BUSY && core_ret)
			ret_cnt_ff <= `VIC_RET_CYCLES;
		else if (state_ff == ST_RET && ret_cnt_ff != 3'h0)
			ret_cnt_ff <= ret_cnt_ff - 3'h1;
		if (state_ff == ST_RET && ret_cnt_ff == 3'h1)
			ret_done_ff <= 1'b1;
	end
end

// ----------------------------------------------------------------------
// Outputs
// ----------------------------------------------------------------------
assign taken_vector = vec_ff;
assign taken_level = lvl_ff;
assign isr_addr = isr_addr_ff;
assign isr_valid = isr_valid_ff;
assign ret_done = ret_done_ff;
assign pm_addr = pm_addr_ff;
assign pm_rd = pm_rd_ff;

// ----------------------------------------------------------------------
// Event status and host interrupt
// ----------------------------------------------------------------------
// Trap and interrupt entries report on separate bits
wire [2:0] evt_set = {ret_done_ff, isr_valid_ff & is_trap_ff,
	isr_valid_ff & ~is_trap_ff};
wire clr_go = wr_go & hit_clr & wb_sel_i[0];
wire [2:0] evt_clr = clr_go ? wb_dat_i[2:0] : 3'h0;

always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n)
		evt_stat_ff <= 3'h0;
	else
		// Set beats clear when both land in one cycle
		evt_stat_ff <= (evt_stat_ff & ~evt_clr) | evt_set;
end

assign host_irq = |(evt_stat_ff & evt_en_ff);

// ----------------------------------------------------------------------
// Wishbone slave
// ----------------------------------------------------------------------
// One wait state: ack one cycle after the strobe, dropped the next
always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n)
		ack_ff <= 1'b0;
	else
		ack_ff <= acc & ~ack_ff;
end

assign wb_ack_o = ack_ff;
assign wb_dat_o = rdat_ff;

// ----------------------------------------------------------------------
// Read data
// ----------------------------------------------------------------------
// Snapshot for debug: request, state, latched level, live winner, vector
wire [31:0] state_word = {core_irq_req, 4'h0, state_ff, 4'h0, lvl_ff,
	win_ok, win_vec, 1'b0, vec_ff};

always @* begin
	nxt_rdat = 32'h0000_0000;
	if (hit_ctrl)
		nxt_rdat[`VIC_ALT_BIT] = alt_sel_ff;
	else if (hit_en)
		nxt_rdat[15:0] = en_eff[en_idx*16 +: 16];
	else if (hit_state)
		nxt_rdat = state_word;
	else if (hit_stat)
		nxt_rdat[2:0] = evt_stat_ff;
	else if (hit_evt_en)
		nxt_rdat[2:0] = evt_en_ff;
	else if (hit_pri)
		nxt_rdat[15:0] = pri_ff[pri_idx*16 +: 16];
end

always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n)
		rdat_ff <= 32'h0000_0000;
	else if (acc && !ack_ff)
		rdat_ff <= nxt_rdat;
end

// ----------------------------------------------------------------------
// Register writes, taken on the ack edge
// ----------------------------------------------------------------------
genvar g;
generate
	for (g = 0; g < 20; g = g + 1) begin : g_pri
		always @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				pri_ff[g*16 +: 16] <= {4{`VIC_PRI_RESET}};
			end else if (wr_go && is_pri(wb_adr_i) && pri_idx == g) begin
				// Level field is three bits, top bit of each nibble stays 0
				if (wb_sel_i[0])
					pri_ff[g*16 +: 8] <= wb_dat_i[7:0] & 8'h77;
				if (wb_sel_i[1])
					pri_ff[g*16+8 +: 8] <= wb_dat_i[15:8] & 8'h77;
			end
		end
	end
	for (g = 0; g < 5; g = g + 1) begin : g_en
		always @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				en_ff[g*16 +: 16] <= 16'h0000;
			end else if (wr_go && is_en(wb_adr_i) && en_idx == g) begin
				if (wb_sel_i[0])
					en_ff[g*16 +: 8] <= wb_dat_i[7:0]
						& en_mask[g*16 +: 8];
				if (wb_sel_i[1])
					en_ff[g*16+8 +: 8] <= wb_dat_i[15:8]
						& en_mask[g*16+8 +: 8];
			end
		end
	end
endgenerate

always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n) begin
		alt_sel_ff <= 1'b0;
		evt_en_ff <= 3'h0;
	end else if (wr_go) begin
		if (wb_adr_i == `VIC_CTRL_OFS && wb_sel_i[1])
			alt_sel_ff <= wb_dat_i[`VIC_ALT_BIT];
		if (wb_adr_i == `VIC_EVT_EN_OFS && wb_sel_i[0])
			evt_en_ff <= wb_dat_i[2:0];
	end
end

endmodule // vic_top

// ==== sim/vic_props.sv ====
// Checker for the interrupt controller, bound to vic_top.
// Assumes one core clock domain and the core handshake on the top ports.
`timescale 1ns/1ps
module vic_props (
	// Clock, reset and bus
	input wire core_clk,
	input wire rst_n,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	// Sources and core
	input wire [4:0] trap_req,
	input wire core_priority_top_bit,
	input wire [2:0] status_priority_field,
	input wire core_irq_req,
	input wire core_irq_ack,
	input wire core_ret,
	input wire [6:0] taken_vector,
	input wire [3:0] taken_level,
	input wire [23:0] isr_addr,
	input wire isr_valid,
	input wire ret_done,
	// Vector fetch
	input wire [23:0] pm_addr,
	input wire pm_rd,
	input wire [23:0] pm_data
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	wire take = core_irq_req && core_irq_ack;
	wire [3:0] lvl = {core_priority_top_bit, status_priority_field};
	wire [23:0] ofs = {16'h0000, taken_vector, 1'b0};
	ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o) else $error("bus ack late");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus ack too long");
	entry_fixed_a: assert property (
		take |-> ##2 pm_rd ##1 isr_valid) else $error("entry latency");
	ret_fixed_a: assert property (
		core_ret |-> ##4 ret_done) else $error("return latency");
	isr_from_mem_a: assert property (
		isr_valid |-> isr_addr == $past(pm_data)) else $error("handler");
	table_addr_a: assert property (
		pm_rd |-> pm_addr == 24'h000004 + ofs
		|| pm_addr == 24'h000100 + ofs) else $error("vector address");
	level_above_a: assert property (
		take && trap_req == 5'h00 |=> taken_level > $past(lvl))
		else $error("level not above core");
	trap_first_a: assert property (
		take && trap_req[0] |=> taken_vector == 7'h00)
		else $error("trap order");
	busy_quiet_a: assert property (
		isr_valid |-> !core_irq_req) else $error("request while busy");
	cover property (take && trap_req != 5'h00);
	cover property (pm_rd && pm_addr >= 24'h000100);
	cover property (ret_done);
endmodule // vic_props

bind vic_top vic_props i_props (.*);

// ==== sim/vic_far_model.sv ====
// Core and program memory model facing the controller.
// Assumes the fetch word is sampled at the edge ending the strobe cycle.
`timescale 1ns/1ps
module vic_far_model (
	// Clock and reset
	input wire core_clk,
	input wire rst_n,
	// Core handshake
	input wire core_irq_req,
	input wire isr_valid,
	output logic core_irq_ack,
	output logic core_ret,
	// Program memory
	input wire pm_rd,
	input wire [23:0] pm_addr,
	output logic [23:0] pm_data
);
	logic [23:0] stale_word;
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			core_irq_ack <= 1'b0;
			core_ret <= 1'b0;
			stale_word <= 24'h000000;
		end else begin
			core_irq_ack <= core_irq_req && !core_irq_ack;
			core_ret <= isr_valid;
			// Stale word inverted so a late sample is caught
			if (pm_rd)
				stale_word <= ~(pm_addr | 24'h800000);
		end
	end
	// Word answers within the strobe cycle
	assign pm_data = pm_rd ? (pm_addr | 24'h800000) : stale_word;
endmodule // vic_far_model

// ==== sim/vic_top_tb.sv ====
// Self-checking bench for vic_top with a core and memory model.
// Assumes handler word equals table address with bit 23 set.
`timescale 1ns/1ps
module vic_top_tb;
	logic core_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i, taken_level;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [79:0] src_irq;
	logic [4:0] trap_req;
	logic core_priority_top_bit, core_irq_req, core_irq_ack, core_ret;
	logic [2:0] status_priority_field;
	logic [6:0] taken_vector;
	logic [23:0] isr_addr, pm_addr, pm_data;
	logic isr_valid, ret_done, pm_rd, host_irq;
	int fail_count = 0;
	int tests_run = 0;
	vic_top i_dut (.*);
	vic_far_model i_far (.*);
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge core_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n == 20) fail_count++;
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic take(input logic [6:0] v, input logic [23:0] a);
		int n;
		n = 0;
		while (isr_valid !== 1'b1 && n < 50) begin
			@(posedge core_clk);
			n++;
		end
		src_irq <= 80'h0;
		trap_req <= 5'h00;
		chk(taken_vector, v);
		chk(isr_addr, a);
		while (ret_done !== 1'b1 && n < 90) begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 50) fail_count++;
		@(posedge core_clk);
	endtask
	task automatic t_regs;
		wb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h0);
		wb(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h4444);
		wb(1'b1, 8'h08, 32'hFFFF);
		wb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h7FFB);
		wb(1'b0, 8'hFC, 32'h0);
		chk(rd, 32'h0);
		$display("regs done");
	endtask
	task automatic t_arb;
		wb(1'b1, 8'h04, 32'h0003);
		src_irq[1:0] <= 2'b11;
		take(7'h08, 24'h800014);
		wb(1'b1, 8'h40, 32'h0054);
		src_irq[1:0] <= 2'b11;
		take(7'h09, 24'h800016);
		wb(1'b1, 8'h04, 32'h0001);
		core_priority_top_bit <= 1'b1;
		src_irq[1:0] <= 2'b11;
		repeat (4) @(posedge core_clk);
		chk(core_irq_req, 32'h0);
		core_priority_top_bit <= 1'b0;
		status_priority_field <= 3'h4;
		repeat (4) @(posedge core_clk);
		chk(core_irq_req, 32'h0);
		status_priority_field <= 3'h3;
		take(7'h08, 24'h800014);
		status_priority_field <= 3'h0;
		$display("arbitration done");
	endtask
	task automatic t_alt_trap;
		wb(1'b1, 8'h00, 32'h8000);
		wb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h8000);
		src_irq[0] <= 1'b1;
		take(7'h08, 24'h800110);
		wb(1'b1, 8'h00, 32'h0);
		src_irq[0] <= 1'b1;
		trap_req <= 5'h14;
		take(7'h02, 24'h800008);
		trap_req <= 5'h10;
		take(7'h04, 24'h80000C);
		trap_req <= 5'h03;
		take(7'h00, 24'h800004);
		$display("table and traps done");
	endtask
	task automatic t_evt;
		wb(1'b1, 8'h38, 32'h7);
		wb(1'b1, 8'h3C, 32'h1);
		chk(host_irq, 32'h0);
		src_irq[0] <= 1'b1;
		take(7'h08, 24'h800014);
		wb(1'b0, 8'h34, 32'h0);
		chk(rd, 32'h5);
		chk(host_irq, 32'h1);
		wb(1'b1, 8'h3C, 32'h0);
		chk(host_irq, 32'h0);
		wb(1'b1, 8'h38, 32'h7);
		wb(1'b0, 8'h34, 32'h0);
		chk(rd, 32'h0);
		$display("events done");
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		rst_n = 1'b0;
		{wb_cyc_i, wb_stb_i, wb_we_i, core_priority_top_bit} = 4'h0;
		{wb_adr_i, wb_dat_i, status_priority_field} = 43'h0;
		{src_irq, trap_req} = 85'h0;
		wb_sel_i = 4'h3;
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		t_regs;
		t_arb;
		t_alt_trap;
		t_evt;
		tally_and_finish;
	end
	// Whole run is well under a thousand cycles, far inside the 10000-cycle limit
	initial begin
		#100000;
		fail_count++;
		tally_and_finish;
	end
endmodule // vic_top_tb
